//--- inc/rbv_pkg.sv
`default_nettype none
package rbv_pkg;
    // ==========================================
    // reset sources, one bit each
    localparam int          SRC_N          = 9;
    localparam int          SRC_POR        = 0;
    localparam int          SRC_PIN        = 1;
    localparam int          SRC_CMP        = 2;
    localparam int          SRC_SW         = 3;
    localparam int          SRC_VMON       = 4;
    localparam int          SRC_SUP        = 5;
    localparam int          SRC_MCD        = 6;
    localparam int          SRC_FLASH      = 7;
    localparam int          SRC_USB        = 8;
    // ==========================================
    // boot and release values
    localparam logic [7:0]  LOADER_SIG     = 8'hA5;
    localparam logic [15:0] RESET_VECTOR   = 16'h0000;
    localparam logic [15:0] LOADER_VECTOR_DEF = 16'hFA00;
    localparam logic [15:0] SIG_ADDR_DEF   = 16'hFBFE;
    localparam logic [7:0]  PORT_LATCH_RST = 8'hFF;
    localparam int          PORT_BYTES     = 5;
    localparam int          PORT_W         = 8 * PORT_BYTES;
    localparam logic [1:0]  CLKSEL_INT_OSC = 2'h0;
    localparam logic [3:0]  SUP_INTERVAL_MAX = 4'hF;
    // flash read latency in cycles of the 40 MHz clock
    localparam logic [1:0]  FLASH_LAT      = 2'h2;

    typedef enum logic [3:0] {
        RBV_HOLD  = 4'h1,
        RBV_ADDR  = 4'h2,
        RBV_WAIT  = 4'h4,
        RBV_RUN   = 4'h8
    } rbv_state_e;
endpackage
`default_nettype wire

//--- inc/rbv_flash_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rbv_flash_if;
    logic        req;
    logic [15:0] addr;
    logic        valid;
    logic [7:0]  data;
    modport seq (output req, output addr, input valid, input data);
    modport rd  (input req, input addr, output valid, output data);
endinterface
`default_nettype wire

//--- logic/rbv_sig_fetch.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// signature fetch: issues one flash read and returns the byte after the
// fixed read latency, as flash answers on flash_rdata at that point
module rbv_sig_fetch
    import rbv_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    rbv_flash_if.rd         fl,
    output var  logic       flash_rd,
    output var  logic [15:0] flash_addr,
    input  wire logic [7:0] flash_rdata
);
    logic [1:0] cnt_q;
    logic       busy_q;
    logic       valid_q;
    logic [7:0] data_q;
    logic       done_w;

    assign done_w   = busy_q && (cnt_q == FLASH_LAT);
    assign fl.valid = valid_q;
    assign fl.data  = data_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q      <= 2'h0;
            busy_q     <= 1'b0;
            valid_q    <= 1'b0;
            data_q     <= 8'h00;
            flash_rd   <= 1'b0;
            flash_addr <= 16'h0000;
        end else begin
            // a new request restarts the read; a read left over from an aborted
            // episode must never hand its valid to the fresh wait state
            valid_q  <= done_w && !fl.req;
            flash_rd <= fl.req;
            if (fl.req) begin
                busy_q     <= 1'b1;
                cnt_q      <= 2'h0;
                flash_addr <= fl.addr;
            end else if (done_w) begin
                busy_q <= 1'b0;
                data_q <= flash_rdata;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/rbv_top.sv
`timescale 1ns/1ps
`default_nettype none
module rbv_top
    import rbv_pkg::*;
#(
    parameter logic [15:0] SIG_ADDR      = SIG_ADDR_DEF,
    parameter logic [15:0] LOADER_VECTOR = LOADER_VECTOR_DEF
)
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               por_req,
    input  wire logic               reset_pin_n_in,
    input  wire logic               cmp_req,
    input  wire logic               sw_req,
    input  wire logic               vmon_req,
    input  wire logic               supervisory_timer_ovf,
    input  wire logic               mcd_req,
    input  wire logic               flash_err_req,
    input  wire logic               usb_req,
    input  wire logic [7:0]         flash_rdata,
    output var  logic               flash_rd,
    output var  logic [15:0]        flash_addr,
    output var  logic               reset_pin_n_out,
    output var  logic               reset_pin_n_oe,
    output var  logic               core_reset,
    output var  logic               core_halt,
    output var  logic               irq_timer_inhibit,
    output var  logic               reg_reset,
    output var  logic               por_reg_reset,
    output var  logic               ram_clear,
    output var  logic [PORT_W-1:0]  port_latch_load,
    output var  logic               port_latch_set,
    output var  logic               port_open_drain,
    output var  logic               port_weak_pullup,
    output var  logic               program_counter_clear,
    output var  logic [15:0]        start_vector,
    output var  logic               start_fetch,
    output var  logic [1:0]         clk_sel,
    output var  logic               supervisory_timer_en,
    output var  logic [3:0]         supervisory_timer_interval,
    output var  logic               loader_present,
    output var  logic [SRC_N-1:0]   last_source
);
    // ==========================================
    // source gathering
    logic [SRC_N-1:0] src_w;
    logic             any_src_w;
    logic             pin_drive_w;
    logic             sig_ok_w;
    rbv_state_e       st_q;
    rbv_state_e       st_d;
    logic             drive_q;
    logic             por_seen_q;
    logic [SRC_N-1:0] src_acc_q;
    logic             loader_q;

    rbv_flash_if fl ();

    assign src_w[SRC_POR]   = por_req;
    assign src_w[SRC_PIN]   = !reset_pin_n_in;
    assign src_w[SRC_CMP]   = cmp_req;
    assign src_w[SRC_SW]    = sw_req;
    assign src_w[SRC_VMON]  = vmon_req;
    assign src_w[SRC_SUP]   = supervisory_timer_ovf;
    assign src_w[SRC_MCD]   = mcd_req;
    assign src_w[SRC_FLASH] = flash_err_req;
    assign src_w[SRC_USB]   = usb_req;
    assign any_src_w        = |src_w;
    // only power-on and supply monitor pull the pin; the timer must not
    assign pin_drive_w      = por_req || vmon_req;
    assign sig_ok_w         = (fl.data == LOADER_SIG);

    // ==========================================
    // sequencer
    assign fl.req  = (st_q == RBV_ADDR);
    assign fl.addr = SIG_ADDR;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            RBV_HOLD: if (!any_src_w) st_d = RBV_ADDR;
            RBV_ADDR: st_d = RBV_WAIT;
            RBV_WAIT: if (fl.valid) st_d = RBV_RUN;
            RBV_RUN:  st_d = RBV_RUN;
            default:  st_d = RBV_HOLD;
        endcase
        // any new source restarts the whole sequence
        if (any_src_w) st_d = RBV_HOLD;
    end

    rbv_sig_fetch u_fetch (
        .clk         (clk),
        .rst         (rst),
        .fl          (fl),
        .flash_rd    (flash_rd),
        .flash_addr  (flash_addr),
        .flash_rdata (flash_rdata)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q       <= RBV_HOLD;
            drive_q    <= 1'b0;
            por_seen_q <= 1'b0;
            src_acc_q  <= '0;
            // block reset counts as a power-on episode for the por-only bits
            src_acc_q[SRC_POR] <= 1'b1;
            loader_q   <= 1'b0;
        end else begin
            st_q <= st_d;
            // pin stays driven until the reset state is left
            if (pin_drive_w) begin
                drive_q <= 1'b1;
            end else if (st_q == RBV_RUN || st_d == RBV_RUN) begin
                drive_q <= 1'b0;
            end
            por_seen_q <= por_req;
            // sources of one reset episode accumulate; a fresh episode restarts
            if (any_src_w) begin
                src_acc_q <= (st_q == RBV_RUN) ? src_w : (src_acc_q | src_w);
            end
            if (st_q == RBV_WAIT && fl.valid) begin
                loader_q <= sig_ok_w;
            end
        end
    end

    // ==========================================
    // registered outputs
    logic in_reset_w;
    logic go_w;
    assign in_reset_w = (st_d != RBV_RUN);
    assign go_w       = (st_q == RBV_WAIT) && (st_d == RBV_RUN);

    always_ff @(posedge clk) begin
        if (rst) begin
            core_reset                 <= 1'b1;
            core_halt                  <= 1'b1;
            irq_timer_inhibit          <= 1'b1;
            reg_reset                  <= 1'b1;
            por_reg_reset              <= 1'b1;
            ram_clear                  <= 1'b0;
            port_latch_load            <= {PORT_BYTES{PORT_LATCH_RST}};
            port_latch_set             <= 1'b1;
            port_open_drain            <= 1'b1;
            port_weak_pullup           <= 1'b1;
            program_counter_clear      <= 1'b1;
            start_vector               <= RESET_VECTOR;
            start_fetch                <= 1'b0;
            clk_sel                    <= CLKSEL_INT_OSC;
            supervisory_timer_en       <= 1'b1;
            supervisory_timer_interval <= SUP_INTERVAL_MAX;
            reset_pin_n_out            <= 1'b0;
            reset_pin_n_oe             <= 1'b0;
            loader_present             <= 1'b0;
            last_source                <= '0;
        end else begin
            core_reset        <= in_reset_w;
            core_halt         <= in_reset_w;
            irq_timer_inhibit <= in_reset_w;
            reg_reset         <= in_reset_w;
            // power-on-only bits reload for a power-on episode and in the first cycle of the episode after it
            por_reg_reset     <= in_reset_w && (por_seen_q || src_acc_q[SRC_POR]);
            ram_clear         <= 1'b0;
            port_latch_load   <= {PORT_BYTES{PORT_LATCH_RST}};
            port_latch_set    <= in_reset_w;
            port_open_drain   <= in_reset_w;
            port_weak_pullup  <= 1'b1;
            reset_pin_n_out   <= 1'b0;
            reset_pin_n_oe    <= pin_drive_w || (drive_q && in_reset_w);
            if (in_reset_w) begin
                program_counter_clear      <= 1'b1;
                clk_sel                    <= CLKSEL_INT_OSC;
                supervisory_timer_en       <= 1'b1;
                supervisory_timer_interval <= SUP_INTERVAL_MAX;
            end else begin
                program_counter_clear <= 1'b0;
            end
            if (go_w) begin
                // choice of vector is made once per reset, whatever the source
                start_vector   <= sig_ok_w ? LOADER_VECTOR : RESET_VECTOR;
                loader_present <= sig_ok_w;
            end
            start_fetch <= go_w;
            if (go_w) begin
                last_source <= src_acc_q;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/rbv_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rbv_top_asserts
    import rbv_pkg::*;
#(
    parameter logic [15:0] SIG_ADDR      = SIG_ADDR_DEF,
    parameter logic [15:0] LOADER_VECTOR = LOADER_VECTOR_DEF
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              por_req,
    input wire logic              reset_pin_n_in,
    input wire logic              cmp_req,
    input wire logic              sw_req,
    input wire logic              vmon_req,
    input wire logic              supervisory_timer_ovf,
    input wire logic              mcd_req,
    input wire logic              flash_err_req,
    input wire logic              usb_req,
    input wire logic              flash_rd,
    input wire logic [15:0]       flash_addr,
    input wire logic              reset_pin_n_out,
    input wire logic              reset_pin_n_oe,
    input wire logic              core_reset,
    input wire logic              core_halt,
    input wire logic              irq_timer_inhibit,
    input wire logic              reg_reset,
    input wire logic              ram_clear,
    input wire logic [PORT_W-1:0] port_latch_load,
    input wire logic              port_latch_set,
    input wire logic              port_open_drain,
    input wire logic              port_weak_pullup,
    input wire logic [15:0]       start_vector,
    input wire logic              start_fetch,
    input wire logic [1:0]        clk_sel,
    input wire logic              supervisory_timer_en,
    input wire logic [3:0]        supervisory_timer_interval,
    input wire logic              loader_present
);
    wire logic any_src = por_req | !reset_pin_n_in | cmp_req | sw_req | vmon_req
        | supervisory_timer_ovf | mcd_req | flash_err_req | usb_req;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    sequence s_read; flash_rd && !any_src ##1 !any_src [*3]; endsequence
    sequence s_go; !core_reset && start_fetch; endsequence
    property p_hold; core_reset |-> core_halt && irq_timer_inhibit && reg_reset; endproperty
    property p_ram; !ram_clear; endproperty
    property p_port; core_reset |-> port_latch_set && port_open_drain && (&port_latch_load);
    endproperty
    property p_pull; port_weak_pullup; endproperty
    property p_drive; (por_req || vmon_req) |=> reset_pin_n_oe && !reset_pin_n_out; endproperty
    property p_oe; reset_pin_n_oe |-> core_reset; endproperty
    property p_src; any_src |=> core_reset; endproperty
    property p_release; s_read |=> s_go; endproperty
    property p_addr; flash_rd |-> flash_addr == SIG_ADDR; endproperty
    property p_exit; $fell(core_reset) |-> start_fetch && clk_sel == CLKSEL_INT_OSC
        && supervisory_timer_en && supervisory_timer_interval == SUP_INTERVAL_MAX
        && start_vector == (loader_present ? LOADER_VECTOR : RESET_VECTOR); endproperty
    property p_pulse; start_fetch |=> !start_fetch; endproperty
    a_hold: assert property (p_hold) else $error("core not held");
    a_ram: assert property (p_ram) else $error("ram cleared");
    a_port: assert property (p_port) else $error("port latches wrong");
    a_pull: assert property (p_pull) else $error("pullups off");
    a_drive: assert property (p_drive) else $error("pin not driven");
    a_oe: assert property (p_oe) else $error("pin driven outside reset");
    a_src: assert property (p_src) else $error("source ignored");
    a_release: assert property (p_release) else $error("release late");
    a_addr: assert property (p_addr) else $error("signature address wrong");
    a_exit: assert property (p_exit) else $error("exit state wrong");
    a_pulse: assert property (p_pulse) else $error("fetch pulse long");
endmodule
bind rbv_top rbv_top_asserts #(.SIG_ADDR(SIG_ADDR), .LOADER_VECTOR(LOADER_VECTOR))
    rbv_top_asserts_inst (.*);
`default_nettype wire

//--- verification/rbv_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// boot flash: answers a read with the signature for six cycles, then
// scrambles so a late sample matches only in a cycle when cnt_q is 8'hFF
module rbv_flash_model (
    input  wire logic       clk,
    input  wire logic       rd,
    input  wire logic [7:0] sig,
    output var  logic [7:0] rdata
);
    logic [2:0] hold_q;
    logic [7:0] cnt_q = 8'h00;
    initial hold_q = 3'h0;
    always_ff @(posedge clk) begin
        cnt_q <= cnt_q + 8'h01;
        if (rd) begin
            hold_q <= 3'h6;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end
    end
    assign rdata = (hold_q != 3'h0) ? sig : (~sig ^ cnt_q);
endmodule
`default_nettype wire

//--- verification/test_reset_and_boot_vector_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_and_boot_vector_select;
    import rbv_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic [8:0] srcs = 9'h000;
    logic [7:0] sig = LOADER_SIG, flash_rdata;
    logic flash_rd, reset_pin_n_out, reset_pin_n_oe, core_reset, core_halt, irq_timer_inhibit;
    logic reg_reset, por_reg_reset, ram_clear, port_latch_set, port_open_drain;
    logic port_weak_pullup, program_counter_clear, start_fetch, supervisory_timer_en;
    logic loader_present;
    logic [15:0] flash_addr, start_vector;
    logic [PORT_W-1:0] port_latch_load;
    logic [1:0] clk_sel;
    logic [3:0] supervisory_timer_interval;
    logic [SRC_N-1:0] last_source;
    int n_fail = 0, num_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    rbv_flash_model rbv_flash_model_inst (.clk, .rd(flash_rd), .sig, .rdata(flash_rdata));
    rbv_top rbv_top_inst (.clk, .rst, .por_req(srcs[0]), .reset_pin_n_in(!srcs[1]),
        .cmp_req(srcs[2]), .sw_req(srcs[3]), .vmon_req(srcs[4]),
        .supervisory_timer_ovf(srcs[5]), .mcd_req(srcs[6]), .flash_err_req(srcs[7]),
        .usb_req(srcs[8]), .flash_rdata, .flash_rd, .flash_addr, .reset_pin_n_out,
        .reset_pin_n_oe, .core_reset, .core_halt, .irq_timer_inhibit, .reg_reset,
        .por_reg_reset, .ram_clear, .port_latch_load, .port_latch_set, .port_open_drain,
        .port_weak_pullup, .program_counter_clear, .start_vector, .start_fetch, .clk_sel,
        .supervisory_timer_en, .supervisory_timer_interval, .loader_present, .last_source);
    // ==========================================
    // helpers
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic wait_go(input logic [15:0] v);
        int n;
        n = 0;
        while (start_fetch !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("fetch", start_fetch, 1);
        check("vector", start_vector, v);
        check("exit", {program_counter_clear, core_reset, loader_present}, v != RESET_VECTOR);
        @(posedge clk);
        #1;
        check("pulse", start_fetch, 0);
    endtask
    // ==========================================
    // scenarios
    task automatic run_src(input int i, input logic [7:0] s);
        @(negedge clk);
        sig = s;
        srcs[i] = 1'b1;
        repeat (3) @(negedge clk);
        check("in reset", {core_reset, core_halt, irq_timer_inhibit}, 3'h7);
        check("pin", reset_pin_n_oe, i == SRC_POR || i == SRC_VMON);
        check("por bits", por_reg_reset, i == SRC_POR);
        check("ports", {port_latch_set, port_open_drain, port_weak_pullup, ram_clear}, 4'hE);
        srcs[i] = 1'b0;
        wait_go(s == LOADER_SIG ? LOADER_VECTOR_DEF : RESET_VECTOR);
        check("source", last_source, 9'h001 << i);
    endtask
    task automatic abort_mid();
        @(negedge clk);
        srcs[SRC_SW] = 1'b1;
        repeat (2) @(negedge clk);
        srcs[SRC_SW] = 1'b0;
        repeat (3) @(negedge clk);
        srcs[SRC_SW] = 1'b1;
        @(negedge clk);
        check("abort", {core_reset, start_fetch}, 2'h2);
        srcs[SRC_SW] = 1'b0;
        wait_go(LOADER_VECTOR_DEF);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        check("rst", {core_reset, reset_pin_n_oe, start_fetch, program_counter_clear}, 4'h9);
        rst = 1'b0;
        wait_go(LOADER_VECTOR_DEF);
        for (int i = 0; i < SRC_N; i++) run_src(i, i[0] ? 8'hA4 : LOADER_SIG);
        abort_mid();
        stop_test();
    end
endmodule
`default_nettype wire
